// >>> src/boot_pkg.sv
package boot_pkg;
    // tile clock
    localparam int unsigned CLK_PERIOD_NS   = 8;
    // internal reset phase, least and longest figure
    localparam int unsigned RESET_MIN_NS    = 15000;
    localparam int unsigned RESET_MAX_NS    = 150000;
    localparam int unsigned RESET_CYCLES    = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESET_MAX_CYC   = RESET_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned CNT_W           = 12;
    // security register
    localparam int unsigned SEC_W           = 32;
    localparam int unsigned SEC_BOOT_BIT    = 5;
    // image format
    localparam logic [31:0] SKIP_CRC        = 32'h0d15ab1e;
    localparam logic [31:0] CRC_POLY        = 32'hedb88320;
    localparam logic [31:0] CRC_INIT        = 32'hffffffff;
    // flash access: quad output read, one command byte, 24 address bits, 8 dummy clocks
    localparam logic [7:0]  FLASH_READ_CMD  = 8'h6b;
    localparam logic [23:0] FLASH_START     = 24'h000000;
    localparam int unsigned CMD_BITS        = 32;
    localparam int unsigned DUMMY_CLKS      = 8;
    // sclk phase counter: low for phases 0..1, high for 2..3
    localparam logic [1:0]  PH_LAST         = 2'h3;
    // otp and ram
    localparam int unsigned OTP_AW          = 11;
    localparam logic [OTP_AW-1:0] OTP_START = 11'h000;
    localparam logic [31:0] RAM_BASE        = 32'h00000000;

    // boot sequence
    typedef enum logic [2:0] {ST_RESET, ST_CMD, ST_DUMMY, ST_DATA, ST_CHECK, ST_RUN, ST_FAIL} boot_state_t;
    // which field of the image is arriving
    typedef enum logic [1:0] {F_COUNT, F_PROG, F_CRC} field_t;
endpackage

// >>> src/crc32_byte.sv
`timescale 1ns/1ns
// registered crc-32 engine, one byte per enable
module crc32_byte (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        init,
    input  wire logic        en,
    input  wire logic [7:0]  data,
    output logic      [31:0] crc_q
);
    import boot_pkg::*;

    logic [31:0] crc_d;  // next register value

    // eight reflected bit steps per byte
    always_comb begin
        logic [31:0] c;
        c = crc_q;
        crc_d = crc_q;
        if (init) begin
            crc_d = CRC_INIT;
        end else if (en) begin
            for (int i = 0; i < 8; i++) begin
                c = ((c[0] ^ data[i]) != 1'b0) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
            end
            crc_d = c;
        end
    end

    // register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            crc_q <= CRC_INIT;
        end else begin
            crc_q <= crc_d;
        end
    end
endmodule // crc32_byte

// >>> src/boot_image_loader.sv
`timescale 1ns/1ns
module boot_image_loader #(
    parameter int unsigned RAM_AW = 15  // word address width of sram
) (
    input  wire logic                          clk,
    input  wire logic                          rst_b,
    input  wire logic [boot_pkg::SEC_W-1:0]    security_reg,
    output logic                               pulldown_en_q,
    output logic                               spi_sclk_q,
    output logic                               spi_cs_b_q,
    output logic      [3:0]                    spi_io_o_q,
    output logic      [3:0]                    spi_io_oe_q,
    input  wire logic [3:0]                    spi_io_i,
    output logic                               otp_rd_q,
    output logic      [boot_pkg::OTP_AW-1:0]   otp_addr_q,
    input  wire logic [31:0]                   otp_rdata,
    output logic                               ram_we_q,
    output logic      [RAM_AW-1:0]             ram_addr_q,
    output logic      [31:0]                   ram_wdata_q,
    output logic                               core_run_q,
    output logic      [31:0]                   start_pc_q,
    output logic                               boot_error_q,
    output logic                               boot_src_otp_q
);
    import boot_pkg::*;

    localparam logic [31:0] RAM_WORDS = 32'(1) << RAM_AW;  // sram size in words

    // elaboration check: refuse sizes the address and reset counters cannot serve
    if (RAM_AW < 1 || RAM_AW > 30) begin : g_bad_ram_aw
        $error("RAM_AW out of range");
    end
    if (RESET_CYCLES >= (1 << CNT_W) || RESET_CYCLES > RESET_MAX_CYC) begin : g_bad_reset_cnt
        $error("reset count does not fit");
    end

    // flash input pins, two-stage synchroniser
    logic [3:0] io_s1_q;  // first stage, read by second only
    logic [3:0] io_s2_q;  // usable sample

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            io_s1_q <= 4'h0;
            io_s2_q <= 4'h0;
        end else begin
            io_s1_q <= spi_io_i;
            io_s2_q <= io_s1_q;
        end
    end

    // sequencer state
    boot_state_t      state_q,  state_d;
    field_t           field_q,  field_d;
    logic [CNT_W-1:0] cnt_q,    cnt_d;     // reset, command and dummy counter
    logic [1:0]       ph_q,     ph_d;      // sclk phase
    logic [31:0]      sh_q,     sh_d;      // command shifter
    logic             nib_q,    nib_d;     // high nibble held
    logic [3:0]       hi_q,     hi_d;      // held high nibble
    logic [31:0]      oword_q,  oword_d;   // otp word being split
    logic [1:0]       obyte_q,  obyte_d;   // byte of otp word
    logic             have_q,   have_d;    // otp word present
    logic [31:0]      asm_q,    asm_d;     // word assembly
    logic [1:0]       bc_q,     bc_d;      // byte within word
    logic [31:0]      size_q,   size_d;    // program size in words
    logic [31:0]      widx_q,   widx_d;    // next ram word
    logic [31:0]      check_q,  check_d;   // trailing check word
    // output next values
    logic                pulldown_d, sclk_d, cs_b_d, otp_rd_d, ram_we_d, run_d, err_d, src_d;
    logic [3:0]          io_o_d, io_oe_d;
    logic [OTP_AW-1:0]   otp_addr_d;
    logic [RAM_AW-1:0]   ram_addr_d;
    logic [31:0]         ram_wdata_d, start_pc_d;
    // byte stream to the consumer
    logic                byte_v;
    logic [7:0]          byte_val;
    logic                flash_on, tick;
    logic [31:0]         crc_q;

    // crc over count and program bytes
    crc32_byte u_crc (
        .clk   (clk),
        .rst_b (rst_b),
        .init  (state_q == ST_RESET),
        .en    (byte_v && field_q != F_CRC),
        .data  (byte_val),
        .crc_q (crc_q)
    );

    // next-state logic of the whole sequence
    always_comb begin
        state_d = state_q; field_d = field_q; cnt_d = cnt_q; sh_d = sh_q;
        nib_d = nib_q; hi_d = hi_q; oword_d = oword_q; obyte_d = obyte_q; have_d = have_q;
        asm_d = asm_q; bc_d = bc_q; size_d = size_q; widx_d = widx_q; check_d = check_q;
        pulldown_d = 1'b0;
        cs_b_d = spi_cs_b_q; io_o_d = spi_io_o_q; io_oe_d = spi_io_oe_q;
        otp_rd_d = 1'b0; otp_addr_d = otp_addr_q; ram_we_d = 1'b0;
        ram_addr_d = ram_addr_q; ram_wdata_d = ram_wdata_q;
        run_d = core_run_q; err_d = boot_error_q; start_pc_d = start_pc_q; src_d = boot_src_otp_q;
        byte_v = 1'b0; byte_val = 8'h00;
        // flash clock runs only while the flash is being read
        flash_on = !boot_src_otp_q && (state_q == ST_CMD || state_q == ST_DUMMY || state_q == ST_DATA);
        ph_d = flash_on ? ph_q + 2'h1 : 2'h0;
        sclk_d = ph_d[1];
        tick = flash_on && ph_q == PH_LAST;  // falling edge next; data sampled now
        unique case (state_q)
            ST_RESET: begin
                // internal reset phase
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CNT_W'(RESET_CYCLES - 1)) begin
                    cnt_d = '0;
                    src_d = security_reg[SEC_BOOT_BIT];
                    if (security_reg[SEC_BOOT_BIT]) begin
                        state_d = ST_DATA;
                        otp_rd_d = 1'b1;
                        otp_addr_d = OTP_START;
                    end else begin
                        state_d = ST_CMD;
                        cs_b_d = 1'b0;
                        sh_d = {FLASH_READ_CMD, FLASH_START};
                        io_oe_d = 4'h1;
                        io_o_d = {3'b000, FLASH_READ_CMD[7]};
                    end
                end
            end
            ST_CMD: begin
                // command and address, msb first on io0
                if (tick) begin
                    sh_d = sh_q << 1;
                    io_o_d = {3'b000, sh_q[30]};
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == CNT_W'(CMD_BITS - 1)) begin
                        state_d = ST_DUMMY;
                        cnt_d = '0;
                        io_oe_d = 4'h0;
                        io_o_d = 4'h0;
                    end
                end
            end
            ST_DUMMY: begin
                // wait clocks before data
                if (tick) begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == CNT_W'(DUMMY_CLKS - 1)) begin
                        state_d = ST_DATA;
                        cnt_d = '0;
                    end
                end
            end
            ST_DATA: begin
                if (!boot_src_otp_q) begin
                    // two nibbles per byte, high first, storage order
                    if (tick) begin
                        nib_d = !nib_q;
                        if (!nib_q) begin
                            hi_d = io_s2_q;
                        end else begin
                            byte_v = 1'b1;
                            byte_val = {hi_q, io_s2_q};
                        end
                    end
                end else if (otp_rd_q) begin
                    // otp word stands while the read strobe is high; taken at the edge that ends it
                    oword_d = otp_rdata;
                    have_d = 1'b1;
                    obyte_d = 2'h0;
                end else if (have_q) begin
                    // bytes of an otp word, least significant first
                    byte_v = 1'b1;
                    byte_val = oword_q[7:0];
                    oword_d = oword_q >> 8;
                    obyte_d = obyte_q + 2'h1;
                    if (obyte_q == 2'h3) begin
                        have_d = 1'b0;
                        otp_rd_d = 1'b1;
                        otp_addr_d = otp_addr_q + 1'b1;
                    end
                end
                // consumer: assemble words lsb first
                if (byte_v) begin
                    asm_d = {byte_val, asm_q[31:8]};
                    bc_d = bc_q + 2'h1;
                    if (bc_q == 2'h3) begin
                        unique case (field_q)
                            F_COUNT: begin
                                size_d = asm_d;
                                widx_d = '0;
                                field_d = (asm_d == 32'h0) ? F_CRC : F_PROG;
                                if (asm_d > RAM_WORDS) begin
                                    state_d = ST_FAIL;
                                    err_d = 1'b1;
                                    cs_b_d = 1'b1;
                                end
                            end
                            F_PROG: begin
                                ram_we_d = 1'b1;
                                ram_addr_d = widx_q[RAM_AW-1:0];
                                ram_wdata_d = asm_d;
                                widx_d = widx_q + 32'h1;
                                if (widx_q + 32'h1 == size_q) field_d = F_CRC;
                            end
                            F_CRC: begin
                                check_d = asm_d;
                                state_d = ST_CHECK;
                                cs_b_d = 1'b1;
                            end
                        endcase
                    end
                end
            end
            ST_CHECK: begin
                // skip marker or inverted residue must match
                if (check_q == SKIP_CRC || ~crc_q == check_q) begin
                    state_d = ST_RUN;
                    run_d = 1'b1;
                    start_pc_d = RAM_BASE;
                end else begin
                    state_d = ST_FAIL;
                    err_d = 1'b1;
                end
            end
            ST_RUN, ST_FAIL: begin
                // hold until next reset
            end
        endcase
    end

    // registers; everything resets while reset pin is low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_RESET; field_q <= F_COUNT; cnt_q <= '0; ph_q <= 2'h0; sh_q <= '0;
            nib_q <= 1'b0; hi_q <= 4'h0; oword_q <= '0; obyte_q <= 2'h0; have_q <= 1'b0;
            asm_q <= '0; bc_q <= 2'h0; size_q <= '0; widx_q <= '0; check_q <= '0;
            pulldown_en_q <= 1'b1;
            spi_sclk_q <= 1'b0; spi_cs_b_q <= 1'b1; spi_io_o_q <= 4'h0; spi_io_oe_q <= 4'h0;
            otp_rd_q <= 1'b0; otp_addr_q <= '0; ram_we_q <= 1'b0; ram_addr_q <= '0;
            ram_wdata_q <= '0; core_run_q <= 1'b0; start_pc_q <= '0; boot_error_q <= 1'b0;
            boot_src_otp_q <= 1'b0;
        end else begin
            state_q <= state_d; field_q <= field_d; cnt_q <= cnt_d; ph_q <= ph_d; sh_q <= sh_d;
            nib_q <= nib_d; hi_q <= hi_d; oword_q <= oword_d; obyte_q <= obyte_d; have_q <= have_d;
            asm_q <= asm_d; bc_q <= bc_d; size_q <= size_d; widx_q <= widx_d; check_q <= check_d;
            pulldown_en_q <= pulldown_d;
            spi_sclk_q <= sclk_d; spi_cs_b_q <= cs_b_d; spi_io_o_q <= io_o_d; spi_io_oe_q <= io_oe_d;
            otp_rd_q <= otp_rd_d; otp_addr_q <= otp_addr_d; ram_we_q <= ram_we_d; ram_addr_q <= ram_addr_d;
            ram_wdata_q <= ram_wdata_d; core_run_q <= run_d; start_pc_q <= start_pc_d; boot_error_q <= err_d;
            boot_src_otp_q <= src_d;
        end
    end

    // checks
    property p_reset_wait;
        @(posedge clk) disable iff (!rst_b)
        (state_q == ST_RESET && cnt_q < CNT_W'(RESET_CYCLES - 1)) |=> state_q == ST_RESET;
    endproperty
    a_reset_wait: assert property (p_reset_wait) else $error("boot left reset phase early");

    property p_pulldown;
        @(posedge clk) disable iff (!rst_b)
        state_q != ST_RESET |-> !pulldown_en_q;
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("pull-downs still on after reset");

    property p_src;
        @(posedge clk) disable iff (!rst_b)
        (state_q != ST_RESET && $past(state_q) == ST_RESET) |-> boot_src_otp_q == $past(security_reg[SEC_BOOT_BIT]);
    endproperty
    a_src: assert property (p_src) else $error("wrong boot source chosen");

    property p_otp_no_flash;
        @(posedge clk) disable iff (!rst_b)
        boot_src_otp_q |-> spi_cs_b_q && !spi_sclk_q;
    endproperty
    a_otp_no_flash: assert property (p_otp_no_flash) else $error("flash touched in otp boot");

    property p_cmd_start;
        @(posedge clk) disable iff (!rst_b)
        $fell(spi_cs_b_q) |-> spi_io_oe_q == 4'h1 && spi_io_o_q[0] == FLASH_READ_CMD[7] && !spi_sclk_q;
    endproperty
    a_cmd_start: assert property (p_cmd_start) else $error("flash command not started correctly");

    property p_prog_bound;
        @(posedge clk) disable iff (!rst_b)
        ram_we_q |-> 32'(ram_addr_q) < size_q && !core_run_q ##1 !ram_we_q;
    endproperty
    a_prog_bound: assert property (p_prog_bound) else $error("ram write outside program");

    property p_skip;
        @(posedge clk) disable iff (!rst_b)
        (state_q == ST_CHECK && check_q == SKIP_CRC) |=> core_run_q && !boot_error_q;
    endproperty
    a_skip: assert property (p_skip) else $error("skip marker did not start program");

    property p_mismatch;
        @(posedge clk) disable iff (!rst_b)
        (state_q == ST_CHECK && check_q != SKIP_CRC && ~crc_q != check_q) |=> boot_error_q && !core_run_q;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("crc mismatch not flagged");

    property p_run_pc;
        @(posedge clk) disable iff (!rst_b)
        $rose(core_run_q) |-> start_pc_q == RAM_BASE ##1 core_run_q[*3];
    endproperty
    a_run_pc: assert property (p_run_pc) else $error("program start address wrong");
endmodule // boot_image_loader

// >>> sim/boot_media_model.sv
`timescale 1ns/1ns
// flash and otp stand-in on the loader's media side
module boot_media_model (
    input  wire logic        clk,
    input  wire logic        spi_sclk_q,
    input  wire logic        spi_cs_b_q,
    input  wire logic [3:0]  spi_io_o_q,
    input  wire logic [3:0]  spi_io_oe_q,
    output logic      [3:0]  spi_io_i,
    input  wire logic        otp_rd_q,
    input  wire logic [10:0] otp_addr_q,
    output logic      [31:0] otp_rdata
);
    logic [7:0]  img [0:1023];  // image bytes in storage order
    logic [31:0] cmd_word;      // command and address bits seen on io0
    int          edges;         // sclk rising edges in this frame
    logic [3:0]  flash_out;     // what the flash puts on its pins
    logic [31:0] otp_word;      // word at the current otp address

    // pin level: the loader's drive wins where it is enabled
    assign spi_io_i = (spi_io_oe_q & spi_io_o_q) | (~spi_io_oe_q & flash_out);

    initial begin
        edges = 0;
        cmd_word = 32'h0;
        flash_out = 4'h5;
    end

    // end of frame: count restarts, released pins flip
    always @(posedge spi_cs_b_q) begin
        edges = 0;
        flash_out = ~flash_out;
    end

    // rising sclk: shift in command and address
    always @(posedge spi_sclk_q) begin
        if (!spi_cs_b_q) begin
            if (edges < 32) begin
                cmd_word = {cmd_word[30:0], spi_io_i[0]};
            end
            edges++;
        end
    end

    // falling sclk after dummies: next nibble, high half first; else toggling pattern
    always @(negedge spi_sclk_q) begin
        if (!spi_cs_b_q && edges >= 40) begin
            flash_out = (edges[0] == 1'b0) ? img[(edges-40)/2][7:4] : img[(edges-40)/2][3:0];
        end else begin
            flash_out = ~flash_out;
        end
    end

    // otp: word stands while the strobe is high, lowest byte at lowest address; else the inverse
    assign otp_word  = {img[4*otp_addr_q+3], img[4*otp_addr_q+2],
                        img[4*otp_addr_q+1], img[4*otp_addr_q]};
    assign otp_rdata = otp_rd_q ? otp_word : ~otp_word;
endmodule // boot_media_model

// >>> sim/boot_image_loader_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("FAIL %s expected %0h seen %0h", n, e, g); end end
module boot_image_loader_tb;
    import boot_pkg::*;
    logic        clk, rst_b, pulldown_en_q, spi_sclk_q, spi_cs_b_q, otp_rd_q, ram_we_q;
    logic        core_run_q, boot_error_q, boot_src_otp_q, cs_seen;
    logic [31:0] security_reg, otp_rdata, ram_wdata_q, start_pc_q;
    logic [3:0]  spi_io_o_q, spi_io_oe_q, spi_io_i;
    logic [10:0] otp_addr_q, first_otp_addr;
    logic [14:0] ram_addr_q;
    logic [31:0] ram [0:63];     // words the loader wrote
    int          errors, comparisons, cyc, start_cyc, wr_n;

    boot_image_loader boot_image_loader_inst (.clk(clk), .rst_b(rst_b), .security_reg(security_reg),
        .pulldown_en_q(pulldown_en_q), .spi_sclk_q(spi_sclk_q), .spi_cs_b_q(spi_cs_b_q),
        .spi_io_o_q(spi_io_o_q), .spi_io_oe_q(spi_io_oe_q), .spi_io_i(spi_io_i), .otp_rd_q(otp_rd_q),
        .otp_addr_q(otp_addr_q), .otp_rdata(otp_rdata), .ram_we_q(ram_we_q), .ram_addr_q(ram_addr_q),
        .ram_wdata_q(ram_wdata_q), .core_run_q(core_run_q), .start_pc_q(start_pc_q),
        .boot_error_q(boot_error_q), .boot_src_otp_q(boot_src_otp_q));
    boot_media_model boot_media_model_inst (.clk(clk), .spi_sclk_q(spi_sclk_q), .spi_cs_b_q(spi_cs_b_q),
        .spi_io_o_q(spi_io_o_q), .spi_io_oe_q(spi_io_oe_q), .spi_io_i(spi_io_i), .otp_rd_q(otp_rd_q),
        .otp_addr_q(otp_addr_q), .otp_rdata(otp_rdata));

    initial begin
        clk = 1'b0;
        // high at start so the first boot's reset is a real falling edge
        rst_b = 1'b1;
        security_reg = 32'h0;
        errors = 0;
        comparisons = 0;
    end
    always #4 clk = ~clk;

    // cycles since release, first media access, ram capture
    always @(posedge clk) begin
        if (rst_b) begin
            cyc++;
            if (!spi_cs_b_q) cs_seen = 1'b1;
            if (start_cyc < 0 && (!spi_cs_b_q || otp_rd_q)) begin
                start_cyc = cyc;
                first_otp_addr = otp_addr_q;
            end
            if (ram_we_q) begin
                `CHK("ram_addr", wr_n[14:0], ram_addr_q)
                ram[wr_n[5:0]] = ram_wdata_q;
                wr_n++;
            end
        end
    end

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // build image (mode 0 good crc, 1 skip marker, 2 bad crc, 3 count over sram size), reset, boot, judge
    task automatic boot(input logic sec, input int words, input int mode);
        logic [31:0] c, chk, cnt, exp;
        logic [7:0]  b;
        int          n, t;
        cnt = (mode == 3) ? 32'h00008001 : 32'(words);  // one word beyond a 32k-word sram
        n = 4 + 4 * words;
        c = CRC_INIT;
        for (int i = 0; i < 1024; i++) boot_media_model_inst.img[i] = 8'(i + 60);
        for (int i = 0; i < n; i++) begin
            b = (i < 4) ? cnt[8*i +: 8] : 8'(i * 37 + 5);
            boot_media_model_inst.img[i] = b;
            c = c ^ {24'h0, b};
            for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        chk = (mode == 1) ? SKIP_CRC : (mode == 2) ? (~c ^ 32'h1) : ~c;
        for (int k = 0; k < 4; k++) boot_media_model_inst.img[n+k] = chk[8*k +: 8];
        @(negedge clk);
        security_reg = 32'h0;
        security_reg[SEC_BOOT_BIT] = sec;
        rst_b = 1'b0;
        repeat (10) @(negedge clk);
        `CHK("pulldown_rst", 1'b1, pulldown_en_q)
        `CHK("cs_rst", 1'b1, spi_cs_b_q)
        `CHK("otp_rd_rst", 1'b0, otp_rd_q)
        `CHK("ram_we_rst", 1'b0, ram_we_q)
        cyc = 0;
        start_cyc = -1;
        wr_n = 0;
        cs_seen = 1'b0;
        rst_b = 1'b1;
        @(negedge clk);
        `CHK("pulldown_run", 1'b0, pulldown_en_q)
        for (t = 0; t < 20000 && core_run_q !== 1'b1 && boot_error_q !== 1'b1; t++) @(negedge clk);
        repeat (20) @(negedge clk);
        `CHK("start_window", 1'b1, start_cyc >= int'(RESET_CYCLES) && start_cyc <= int'(RESET_MAX_CYC))
        `CHK("src_otp", sec, boot_src_otp_q)
        `CHK("core_run", mode < 2, core_run_q)
        `CHK("boot_error", mode >= 2, boot_error_q)
        `CHK("cs_idle", 1'b1, spi_cs_b_q)
        `CHK("words", words, wr_n)
        if (mode < 2) `CHK("start_pc", RAM_BASE, start_pc_q)
        for (int i = 0; i < words; i++) begin
            for (int k = 0; k < 4; k++) exp[8*k +: 8] = boot_media_model_inst.img[4 + 4*i + k];
            `CHK("ram_word", exp, ram[i])
        end
    endtask

    task automatic t_flash_crc;
        boot(1'b0, 3, 0);
        `CHK("flash_cmd", {FLASH_READ_CMD, FLASH_START}, boot_media_model_inst.cmd_word)
        `CHK("flash_used", 1'b1, cs_seen)
        $display("test flash_crc done");
    endtask

    task automatic t_flash_skip;
        boot(1'b0, 0, 1);
        $display("test flash_skip done");
    endtask

    task automatic t_flash_bad;
        boot(1'b0, 2, 2);
        $display("test flash_bad done");
    endtask

    task automatic t_flash_big;
        boot(1'b0, 0, 3);
        $display("test flash_big done");
    endtask

    task automatic t_otp_crc;
        boot(1'b1, 4, 0);
        `CHK("otp_first_addr", OTP_START, first_otp_addr)
        `CHK("flash_unused", 1'b0, cs_seen)
        $display("test otp_crc done");
    endtask

    task automatic t_otp_skip;
        boot(1'b1, 1, 1);
        $display("test otp_skip done");
    endtask

    // watchdog: six boots need about 12500 cycles
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        stop_test();
    end

    initial begin
        t_flash_crc();
        t_flash_skip();
        t_flash_bad();
        t_flash_big();
        t_otp_crc();
        t_otp_skip();
        stop_test();
    end
endmodule // boot_image_loader_tb
